// ===== hdl/atm_tc_core.sv
// Purpose: cell transmit check insertion, idle fill, delineation, header
//   error handling and forwarding to the cell layer
// Assumes: octet boundaries known on receive, descrambler outside
// Notes: one clock, line_tick_i paces transmit octets
// Contract
// R1 - check octet is remainder of header times x^8 by x^8+x^2+x+1.
// R2 - first header bit is the highest-order polynomial coefficient.
// R3 - remainder register cleared to zero before each header.
// R4 - check bits XORed with 01010101 before going into octet five.
// R5 - receiver removes the same pattern before computing the syndrome.
// R6 - correction mode fixes single-bit error, then detection; multi-bit discards.
// R7 - detection mode discards every errored header and corrects nothing.
// R8 - error-free header selects correction mode and passes unchanged.
// R9 - correct only while locked and descrambler steady; else detect only.
// R10 - idle header is 00 00 00 01 with check octet 01010010.
// R11 - idle payload is 01101010 repeated 48 times.
// R12 - idle cells serve delineation only, never forwarded to cell layer.
// R13 - delineation tests 32 header bits against 8 check bits.
// R14 - search tests every position for zero syndrome, confirm on match.
// R15 - with known octet boundaries search may step octet by octet.
// R16 - six check bits compared before descrambler steady, all eight after.
// R17 - confirm locks after 8 good checks, any bad returns to search.
// R18 - locked returns to search after 7 consecutive bad; good clears.
// R19 - locked forwards good or fixed cells only with descrambler steady.
// R20 - link uses additive distributed-sample scrambler without error spread.
// R21 - cells are 53 octets, five header octets, sent back to back.
// R22 - falling back to search tells descrambler to reacquire.
// R23 - reset gives search state, correction mode, counters cleared.
// R24 - events for lock gained or lost, header fixed, cell dropped.
`timescale 1ns/1ns
`include "hec_consts.svh"

module atm_tc_core
  import hec_pkg::*;
#(
  parameter logic [3:0] confirm_need = `CONFIRM_NEED,
  parameter logic [3:0] loss_threshold = `LOSS_THRESHOLD
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic line_tick_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic [7:0] tx_line_o,
  output logic tx_line_stb_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic descr_steady_i,
  output logic cell_valid_o,
  output logic cell_sop_o,
  output logic [7:0] cell_data_o,
  output logic descr_reacq_o,
  output logic lock_o,
  output logic lock_gain_o,
  output logic lock_lost_o,
  output logic hdr_fixed_o,
  output logic hdr_drop_o,
  output logic corr_mode_o
);

  // transmit side state
  logic [5:0] tx_pos_q;
  logic tx_user_q;
  logic [7:0] tx_crc_q;
  logic tx_user_d;
  logic [7:0] tx_byte;
  logic [5:0] tx_pos_d;
  logic [31:0] idle_hdr_sh;

  // receive side state
  hdr_if hi ();
  delin_state_t state_q;
  logic [39:0] win_q;
  logic new_q;
  logic [5:0] pos_q;
  logic [3:0] cnt_q;
  logic corr_q;
  logic fwd_q;
  logic [5:0] out_cnt_q;
  logic hit;
  logic chk;
  logic fix_ok;
  logic accept;
  logic [39:0] base;
  logic [5:0] out_n;

  hec_check u_chk (
    .h(hi)
  );

  // window to the checker; the additive descrambler outside never spreads
  // a line error, so a single-bit syndrome stays trustworthy
  assign hi.hdr = win_q;
  assign hi.full = descr_steady_i; // [R16] [R20]

  // transmit slot decode; idle header octets taken from a shifted pattern
  always_comb begin
    idle_hdr_sh = `IDLE_HDR << {tx_pos_q[1:0], 3'b000};
    tx_user_d = (tx_pos_q == 6'h00) ? tx_valid_i : tx_user_q;
    tx_pos_d = (tx_pos_q == `CELL_OCTETS - 6'h01) ? 6'h00 :
               6'(tx_pos_q + 6'h01); // [R21]
    if (tx_pos_q < `HEC_SLOT) begin
      tx_byte = tx_user_d ? tx_data_i : idle_hdr_sh[31:24]; // [R10]
    end else if (tx_pos_q == `HEC_SLOT) begin
      tx_byte = tx_crc_q ^ `HEC_COSET; // [R4] [R1]
    end else begin
      tx_byte = tx_user_q ? tx_data_i : `IDLE_PAYLOAD; // [R11]
    end
  end

  // transmit octet counter, cell kind and line register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_pos_q <= 6'h00;
      tx_user_q <= 1'b0;
      tx_line_o <= 8'h00;
      tx_line_stb_o <= 1'b0;
      tx_ready_o <= 1'b1;
    end else begin
      tx_line_stb_o <= line_tick_i;
      if (line_tick_i) begin
        tx_pos_q <= tx_pos_d;
        tx_user_q <= tx_user_d;
        tx_line_o <= tx_byte;
        // ready reflects whether the coming slot consumes cell-layer data
        tx_ready_o <= (tx_pos_d == 6'h00) ||
                      (tx_user_d && tx_pos_d != `HEC_SLOT);
      end
    end
  end

  // running remainder, restarted from zero at every header [R3] [R2]
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_crc_q <= 8'h00;
    end else if (line_tick_i && tx_pos_q < `HEC_SLOT) begin
      tx_crc_q <= hec_rem((tx_pos_q == 6'h00) ? 8'h00 : tx_crc_q, tx_byte);
    end
  end

  // search hit on any octet position, header check once per cell
  assign hit = new_q && state_q == search_state && hi.ok; // [R14] [R15]
  assign chk = new_q && state_q != search_state && pos_q == `HDR_CHECK_POS;
  assign fix_ok = chk && !hi.ok && hi.single && corr_q &&
                  state_q == locked_state && descr_steady_i; // [R9] [R6]
  assign accept = chk && (hi.ok || fix_ok) && !hi.idle &&
                  state_q == locked_state && descr_steady_i; // [R19] [R12]
  assign base = accept ? {hi.fixed, win_q[7:0]} : win_q;
  assign out_n = accept ? 6'h00 : out_cnt_q;

  // five-octet window; a corrected header is written back before leaving
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_q <= 40'h0;
      new_q <= 1'b0;
    end else begin
      new_q <= rx_valid_i;
      if (rx_valid_i) begin
        win_q <= {base[31:0], rx_data_i};
      end else begin
        win_q <= base;
      end
    end
  end

  // octet position within the current received cell
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_q <= 6'h00;
    end else if (hit) begin
      pos_q <= rx_valid_i ? 6'(`HDR_CHECK_POS + 6'h01) : `HDR_CHECK_POS;
    end else if (rx_valid_i) begin
      pos_q <= (pos_q == `CELL_OCTETS) ? 6'h01 : 6'(pos_q + 6'h01);
    end
  end

  // delineation state machine and its events [R23]
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= search_state;
      cnt_q <= 4'h0;
      lock_o <= 1'b0;
      descr_reacq_o <= 1'b0;
      lock_gain_o <= 1'b0;
      lock_lost_o <= 1'b0;
    end else begin
      descr_reacq_o <= 1'b0;
      lock_gain_o <= 1'b0;
      lock_lost_o <= 1'b0;
      if (hit) begin
        state_q <= confirm_state; // [R14]
        cnt_q <= 4'h0;
      end else if (chk) begin
        unique case (state_q)
          confirm_state: begin
            if (!hi.ok) begin
              state_q <= search_state; // [R17]
              descr_reacq_o <= 1'b1; // [R22]
            end else if (cnt_q == 4'(confirm_need - 4'h1)) begin
              state_q <= locked_state; // [R17]
              cnt_q <= 4'h0;
              lock_o <= 1'b1;
              lock_gain_o <= 1'b1; // [R24]
            end else begin
              cnt_q <= 4'(cnt_q + 4'h1);
            end
          end
          locked_state: begin
            if (hi.ok) begin
              cnt_q <= 4'h0; // [R18]
            end else if (cnt_q == 4'(loss_threshold - 4'h1)) begin
              state_q <= search_state; // [R18]
              cnt_q <= 4'h0;
              lock_o <= 1'b0;
              descr_reacq_o <= 1'b1; // [R22]
              lock_lost_o <= 1'b1; // [R24]
            end else begin
              cnt_q <= 4'(cnt_q + 4'h1);
            end
          end
          default: begin
            state_q <= search_state;
            cnt_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // header error handler mode and its events
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      corr_q <= 1'b1; // [R23]
      hdr_fixed_o <= 1'b0;
      hdr_drop_o <= 1'b0;
    end else begin
      hdr_fixed_o <= fix_ok; // [R24]
      // a header judged outside lock is not forwarded; an errored one in confirm still counts as a drop
      hdr_drop_o <= chk && !hi.ok && !fix_ok; // [R7] [R24]
      if (chk) begin
        corr_q <= hi.ok; // [R8] [R6] [R7]
      end
    end
  end
  assign corr_mode_o = corr_q;

  // forwarding: octets leave the window five behind, check octet skipped
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_q <= 1'b0;
      out_cnt_q <= 6'h00;
      cell_valid_o <= 1'b0;
      cell_sop_o <= 1'b0;
      cell_data_o <= 8'h00;
    end else begin
      cell_valid_o <= 1'b0;
      cell_sop_o <= 1'b0;
      if (accept) begin
        fwd_q <= 1'b1;
        out_cnt_q <= 6'h00;
      end
      if (rx_valid_i && (accept || fwd_q)) begin
        cell_valid_o <= out_n != `HEC_SLOT;
        cell_sop_o <= out_n == 6'h00;
        cell_data_o <= base[39:32];
        out_cnt_q <= 6'(out_n + 6'h01);
        if (out_n == `CELL_OCTETS - 6'h01) begin
          fwd_q <= 1'b0;
        end
      end
    end
  end

  // helper state for the checks below
  logic [5:0] a_lpos_q;
  logic a_luser_q;
  logic [31:0] a_hdr_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_lpos_q <= 6'h00;
      a_luser_q <= 1'b0;
      a_hdr_q <= 32'h0;
    end else if (line_tick_i) begin
      a_lpos_q <= tx_pos_q;
      a_luser_q <= tx_user_d;
      if (tx_pos_q < `HEC_SLOT) begin
        a_hdr_q <= {a_hdr_q[23:0], tx_byte};
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_tx_hec_coset: assert property ( // [R1]
    tx_line_stb_o && a_lpos_q == `HEC_SLOT |->
      tx_line_o == (hdr_crc(a_hdr_q) ^ `HEC_COSET))
    else $error("transmitted check octet wrong");
  a_idle_hdr_hec: assert property ( // [R10]
    tx_line_stb_o && !a_luser_q && a_lpos_q == `HEC_SLOT |->
      tx_line_o == 8'h52)
    else $error("idle check octet wrong");
  a_idle_payload: assert property ( // [R11]
    tx_line_stb_o && !a_luser_q && a_lpos_q > `HEC_SLOT |->
      tx_line_o == `IDLE_PAYLOAD)
    else $error("idle payload octet wrong");
  a_search_hit_confirm: assert property ( // [R14]
    state_q == search_state && new_q && hi.ok |=>
      state_q == confirm_state && cnt_q == 4'h0)
    else $error("search match did not enter confirm");
  a_confirm_bad_search: assert property ( // [R17]
    chk && state_q == confirm_state && !hi.ok |=>
      state_q == search_state && descr_reacq_o)
    else $error("bad check in confirm not handled");
  a_confirm_to_lock: assert property ( // [R17]
    chk && state_q == confirm_state && hi.ok && cnt_q == 4'h7 |=>
      state_q == locked_state && lock_gain_o ##1 !lock_gain_o)
    else $error("lock not reached after good checks");
  a_lock_loss_count: assert property ( // [R18]
    chk && state_q == locked_state && !hi.ok && cnt_q == 4'h6 |=>
      state_q == search_state && lock_lost_o && descr_reacq_o && !lock_o)
    else $error("lock not lost after bad checks");
  a_mode_after_check: assert property ( // [R6]
    chk |=> corr_q == $past(hi.ok))
    else $error("handler mode wrong after check");
  a_fix_gated_lock: assert property ( // [R9]
    hdr_fixed_o |-> $past(state_q) == locked_state &&
      $past(descr_steady_i) && $past(corr_q))
    else $error("correction outside lock or steady state");
  a_fwd_only_locked: assert property ( // [R19]
    $rose(fwd_q) |-> $past(state_q) == locked_state &&
      $past(descr_steady_i) && !$past(hi.idle))
    else $error("cell forwarded outside lock");

  c_lock_gained: cover property (lock_gain_o);
  c_header_fixed: cover property (hdr_fixed_o);
  c_cell_forwarded: cover property (cell_sop_o);
  c_lock_lost: cover property (lock_lost_o);

endmodule

// ===== hdl/hdr_if.sv
// Purpose: carrier between the core and the header checker
// Assumes: purely combinational check
// Notes: hdr holds 5 octets, first octet in [39:32]
`timescale 1ns/1ns

interface hdr_if;
  logic [39:0] hdr;
  logic full;
  logic ok;
  logic single;
  logic idle;
  logic [31:0] fixed;

  modport chk (input hdr, input full,
               output ok, output single, output idle, output fixed);
  modport core (output hdr, output full,
                input ok, input single, input idle, input fixed);
endinterface

// ===== hdl/hec_check.sv
// Purpose: syndrome, single-bit locator and idle detect for one header
// Assumes: coset pattern already applied by the far transmitter
// Notes: single is also set for an error inside the check octet
`timescale 1ns/1ns
`include "hec_consts.svh"

module hec_check
  import hec_pkg::*;
(
  hdr_if.chk h
);

  logic [7:0] syn;
  logic [31:0] fixed;
  logic single;

  // syndrome over header and de-cosetted check octet [R5] [R13]
  always_comb begin
    syn = hdr_crc(h.hdr[39:8]) ^ h.hdr[7:0] ^ `HEC_COSET;
    fixed = h.hdr[39:8];
    single = $onehot(syn);
    // constant syndromes per position fold away in synthesis
    for (int i = 0; i < 32; i++) begin
      if (hdr_crc(32'h1 << i) == syn) begin
        fixed[i] = ~fixed[i];
        single = 1'b1;
      end
    end
  end

  // only six check bits are trusted before descrambler lock [R16]
  assign h.ok = (syn & (h.full ? `HEC_MASK_FULL : `HEC_MASK_PART)) == 8'h00;
  assign h.single = single;
  assign h.fixed = fixed;
  assign h.idle = fixed == `IDLE_HDR;

endmodule

// ===== hdl/hec_consts.svh
// Purpose: shared numeric constants for the cell transmission convergence
// Assumes: octet-wide datapath, first transmitted bit in bit 7
// Notes: definitions only
`ifndef HEC_CONSTS_SVH
`define HEC_CONSTS_SVH

`define HEC_POLY 8'h07
`define HEC_COSET 8'h55
`define HEC_MASK_FULL 8'hFF
`define HEC_MASK_PART 8'h3F
`define CELL_OCTETS 6'h35
`define HEC_SLOT 6'h04
`define HDR_CHECK_POS 6'h05
`define IDLE_HDR 32'h00000001
`define IDLE_PAYLOAD 8'h6A
`define CONFIRM_NEED 4'h8
`define LOSS_THRESHOLD 4'h7

`endif

// ===== hdl/hec_pkg.sv
// Purpose: types and header check arithmetic
// Assumes: hec_consts.svh on the include path
// Notes: msb of each octet is the first bit on the line
`include "hec_consts.svh"

package hec_pkg;

  typedef enum logic [1:0] {
    search_state = 2'b00,
    confirm_state = 2'b01,
    locked_state = 2'b10
  } delin_state_t;

  // one octet through the x^8+x^2+x+1 divider, msb first
  function automatic logic [7:0] hec_rem(input logic [7:0] r,
                                         input logic [7:0] b);
    logic [7:0] c;
    logic fb;
    c = r;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ b[i];
      c = {c[6:0], 1'b0} ^ (fb ? `HEC_POLY : 8'h00);
    end
    return c;
  endfunction

  // check value of a 32-bit header, divider starting at zero
  function automatic logic [7:0] hdr_crc(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < 4; k++) begin
      c = hec_rem(c, h[31-8*k -: 8]);
    end
    return c;
  endfunction

endpackage

// ===== testbench/atm_hec_cell_delineation_tb_top.sv
// Purpose: self-checking bench for the cell convergence core
// Assumes: far-end model drives received octets at the falling edge
// Notes: a monitor gathers forwarded octets and event pulses
`timescale 1ns/1ns

module atm_hec_cell_delineation_tb_top;
  localparam logic [31:0] UHDR = 32'h0A1B2C3D;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic line_tick_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic descr_steady_i = 1'b0;
  logic rx_valid_i;
  logic [7:0] rx_data_i;
  logic tx_ready_o, tx_line_stb_o, cell_valid_o, cell_sop_o;
  logic [7:0] tx_line_o;
  logic [7:0] cell_data_o;
  logic descr_reacq_o, lock_o, lock_gain_o, lock_lost_o;
  logic hdr_fixed_o, hdr_drop_o, corr_mode_o;
  logic [7:0] fwd_q[$];
  int sop_n, gain_n, lost_n, reacq_n, fixed_n, drop_n;
  int fails = 0;
  int samples_checked = 0;

  always #10 core_clk_i = ~core_clk_i;

  atm_tc_core u_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .line_tick_i(line_tick_i),
    .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .tx_line_o(tx_line_o),
    .tx_line_stb_o(tx_line_stb_o), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .descr_steady_i(descr_steady_i),
    .cell_valid_o(cell_valid_o), .cell_sop_o(cell_sop_o),
    .cell_data_o(cell_data_o), .descr_reacq_o(descr_reacq_o),
    .lock_o(lock_o), .lock_gain_o(lock_gain_o),
    .lock_lost_o(lock_lost_o), .hdr_fixed_o(hdr_fixed_o),
    .hdr_drop_o(hdr_drop_o), .corr_mode_o(corr_mode_o)
  );

  line_tx_model u_far (
    .core_clk_i(core_clk_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i)
  );

  // sampled mid-cycle, where every registered output has settled
  always @(negedge core_clk_i) begin
    if (cell_valid_o === 1'b1) fwd_q.push_back(cell_data_o);
    if (cell_sop_o === 1'b1) sop_n++;
    if (lock_gain_o === 1'b1) gain_n++;
    if (lock_lost_o === 1'b1) lost_n++;
    if (descr_reacq_o === 1'b1) reacq_n++;
    if (hdr_fixed_o === 1'b1) fixed_n++;
    if (hdr_drop_o === 1'b1) drop_n++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic clr;
    fwd_q.delete();
    {sop_n, gain_n, lost_n, reacq_n, fixed_n, drop_n} = '0;
  endtask

  // events land two cycles after the octet that completes a check
  task automatic settle;
    repeat (3) @(negedge core_clk_i);
  endtask

  task automatic t_reset;
    chk(lock_o, 1'b0);
    chk(corr_mode_o, 1'b1);
    chk(tx_ready_o, 1'b1);
    chk(cell_valid_o, 1'b0);
  endtask

  // one transmitted cell, ticks two cycles apart
  task automatic t_tx(input logic user, input logic [31:0] h);
    logic [7:0] e;
    for (int i = 0; i < 53; i++) begin
      @(negedge core_clk_i);
      if (i == 0 || i == 4) chk(tx_ready_o, i == 0);
      if (i == 5) chk(tx_ready_o, user);
      tx_valid_i = user;
      tx_data_i = (i < 4) ? h[31-8*i -: 8] : 8'(8'h20 + i);
      line_tick_i = 1'b1;
      @(negedge core_clk_i);
      line_tick_i = 1'b0;
      if (i < 4) e = h[31-8*i -: 8];
      else if (i == 4) e = user ? (u_far.crc8(h) ^ 8'h55) : 8'h52;
      else e = user ? 8'(8'h20 + i) : 8'h6A;
      chk(tx_line_stb_o, 1'b1);
      chk(tx_line_o, e);
    end
    tx_valid_i = 1'b0;
  endtask

  // top two check bits spoilt: only the low six may count
  task automatic t_lock;
    clr();
    repeat (8) u_far.send_cell(32'h1, 32'h0, 8'hC0, 1'b0);
    chk(lock_o, 1'b0);
    u_far.send_cell(32'h1, 32'h0, 8'hC0, 1'b0);
    settle();
    chk(lock_o, 1'b1);
    chk(gain_n, 1);
    chk(fwd_q.size(), 0);
  endtask

  task automatic t_fwd;
    clr();
    descr_steady_i = 1'b1;
    u_far.send_cell(UHDR, 32'h0, 8'h00, 1'b1);
    u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    settle();
    chk(fwd_q.size(), 52);
    chk(sop_n, 1);
    for (int k = 0; k < 4; k++) chk(fwd_q[k], UHDR[31-8*k -: 8]);
    chk(fwd_q[4], 8'h25);
    chk(fwd_q[51], 8'h54);
  endtask

  task automatic t_hec;
    clr();
    u_far.send_cell(UHDR, 32'h00100000, 8'h00, 1'b1);
    chk(fixed_n, 1);
    chk(corr_mode_o, 1'b0);
    u_far.send_cell(UHDR, 32'h00000400, 8'h00, 1'b1);
    chk(drop_n, 1);
    chk(fixed_n, 1);
    u_far.send_cell(UHDR, 32'h0, 8'h00, 1'b1);
    chk(corr_mode_o, 1'b1);
    u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    settle();
    chk(fwd_q.size(), 104);
    for (int k = 0; k < 4; k++) chk(fwd_q[k], UHDR[31-8*k -: 8]);
    chk(fwd_q[52], UHDR[31:24]);
    chk(lock_o, 1'b1);
  endtask

  task automatic bad_cells(input int n);
    repeat (n) u_far.send_cell(32'h1, 32'h00810000, 8'h00, 1'b0);
  endtask

  // a good check in between restarts the count of bad ones
  task automatic t_loss;
    clr();
    bad_cells(6);
    u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    bad_cells(6);
    chk(lock_o, 1'b1);
    chk(lost_n, 0);
    bad_cells(1);
    settle();
    chk(lock_o, 1'b0);
    chk(lost_n, 1);
    chk(reacq_n, 1);
    chk(fwd_q.size(), 0);
    chk(drop_n, 13);
  endtask

  task automatic t_confirm;
    clr();
    repeat (4) u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    bad_cells(1);
    repeat (8) u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    settle();
    chk(lock_o, 1'b0);
    u_far.send_cell(32'h1, 32'h0, 8'h00, 1'b0);
    settle();
    chk(lock_o, 1'b1);
    chk(gain_n, 1);
    chk(drop_n, 1);
    chk(reacq_n, 1);
  endtask

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge core_clk_i);
    rstn_i = 1'b1;
    @(negedge core_clk_i);
    t_reset();
    t_tx(1'b0, 32'h1);
    t_tx(1'b1, UHDR);
    t_lock();
    t_fwd();
    t_hec();
    t_loss();
    t_confirm();
    // reset again while locked: state and mode must fall back
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    @(negedge core_clk_i);
    t_reset();
    summarize();
  end
endmodule

// ===== testbench/line_tx_model.sv
// Purpose: far-end line transmitter feeding received octets
// Assumes: octet aligned, already descrambled stream
// Notes: a released data line toggles so a stale octet never passes
`timescale 1ns/1ns

module line_tx_model (
  input wire logic core_clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  // msb-first divider by x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end

  // one whole cell; hx and cx inject header errors on request
  task automatic send_cell(input logic [31:0] h, input logic [31:0] hx,
                           input logic [7:0] cx, input logic user);
    logic [39:0] hdr;
    hdr = {h ^ hx, crc8(h) ^ 8'h55 ^ cx};
    for (int i = 0; i < 53; i++) begin
      @(negedge core_clk_i);
      rx_valid_o = 1'b1;
      if (i < 5) rx_data_o = hdr[39-8*i -: 8];
      else rx_data_o = user ? 8'(8'h20 + i) : 8'h6A;
    end
    @(negedge core_clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule
